// ==== rtl/tpef_map.svh ====
`ifndef TPEF_MAP_SVH
`define TPEF_MAP_SVH

// register byte addresses on the register port
`define TPEF_ADDR_CFG 8'h21
`define TPEF_ADDR_SRC 8'h22
`define TPEF_ADDR_THX 8'h23
`define TPEF_ADDR_THY 8'h24
`define TPEF_ADDR_THZ 8'h25
`define TPEF_ADDR_TMLT 8'h26
`define TPEF_ADDR_LTCY 8'h27

// configuration register fields
`define TPEF_CFG_ABORT 7
`define TPEF_CFG_LATCH 6
`define TPEF_CFG_ZD 5
`define TPEF_CFG_ZS 4
`define TPEF_CFG_YD 3
`define TPEF_CFG_YS 2
`define TPEF_CFG_XD 1
`define TPEF_CFG_XS 0

// status register fields
`define TPEF_SRC_ACTIVE 7
`define TPEF_SRC_AZ 6
`define TPEF_SRC_AY 5
`define TPEF_SRC_AX 4
`define TPEF_SRC_DOUBLE 3
`define TPEF_SRC_PZ 2
`define TPEF_SRC_PY 1
`define TPEF_SRC_PX 0

// widths, reset values and counter constants
`define TPEF_THS_W 7
`define TPEF_RST8 8'h00
`define TPEF_RST7 7'h00
`define TPEF_CNT0 8'h00
`define TPEF_CNT_STEP 8'h01
`define TPEF_DBL_WIN_DEF 8'hff

`endif

// ==== rtl/tpef_pkg.sv ====
package tpef_pkg;
	// detector states, gray coded along idle-hit-latency-wait-hit
	typedef enum logic [2:0] {
		TPEF_IDLE = 3'h0,
		TPEF_HIT1 = 3'h1,
		TPEF_LAT = 3'h3,
		TPEF_WAIT2 = 3'h2,
		TPEF_HIT2 = 3'h6,
		TPEF_STUCK = 3'h5
	} tpef_state_t;

	typedef logic [7:0] tpef_byte_t;
	typedef logic [6:0] tpef_ths_t;
	typedef logic [2:0] tpef_axes_t;
endpackage

// ==== rtl/tpef_axis_det.sv ====
`timescale 1ns/1ps
`include "tpef_map.svh"

module tpef_axis_det #(
	parameter int ACC_W = 8
) (
	input logic clock,
	input logic reset,
	input logic ce,
	input logic tick,
	input logic signed [ACC_W-1:0] acc,
	input tpef_pkg::tpef_ths_t thr,
	input tpef_pkg::tpef_byte_t tmlt,
	input tpef_pkg::tpef_byte_t ltcy,
	input tpef_pkg::tpef_byte_t win,
	input logic double_tap_abort,
	output logic single_evt,
	output logic double_evt,
	output logic evt_neg
);
	import tpef_pkg::*;

	tpef_state_t st_r, st_nxt;
	tpef_byte_t cnt_r, cnt_nxt;
	logic sign_r, sign_nxt;
	logic lat_hit_r, lat_hit_nxt;
	logic abort_r, abort_nxt;
	logic single_nxt, double_nxt, neg_nxt;

	// magnitude compare; sign bit gives pulse polarity
	wire [ACC_W-1:0] acc_u = acc;
	wire acc_neg = acc_u[ACC_W-1];
	wire [ACC_W-1:0] acc_mag = acc_neg ? (~acc_u + {{(ACC_W-1){1'b0}}, 1'b1}) : acc_u;
	wire [ACC_W-1:0] thr_ext = {{(ACC_W-`TPEF_THS_W){1'b0}}, thr};
	wire above = acc_mag > thr_ext;
	wire [7:0] cnt_inc = cnt_r + `TPEF_CNT_STEP;

	// next state: advances only on a sample tick
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sign_nxt = sign_r;
		lat_hit_nxt = lat_hit_r;
		abort_nxt = abort_r;
		single_nxt = 1'b0;
		double_nxt = 1'b0;
		neg_nxt = sign_r;
		if (tick) begin
			case (st_r)
				TPEF_IDLE: begin
					if (above) begin
						st_nxt = TPEF_HIT1;
						cnt_nxt = `TPEF_CNT0;
						sign_nxt = acc_neg;
					end
				end
				TPEF_HIT1: begin
					if (!above) begin
						single_nxt = 1'b1;
						neg_nxt = sign_r;
						st_nxt = TPEF_LAT;
						cnt_nxt = `TPEF_CNT0;
						lat_hit_nxt = 1'b0;
						abort_nxt = 1'b0;
					end else if (cnt_r == tmlt) begin
						st_nxt = TPEF_STUCK;
					end else begin
						cnt_nxt = cnt_inc;
					end
				end
				TPEF_LAT: begin
					// pulses here never report; abort only matters with the abort bit set
					if (above)
						lat_hit_nxt = 1'b1;
					if (!above && lat_hit_r && double_tap_abort)
						abort_nxt = 1'b1;
					if (cnt_r == ltcy) begin
						st_nxt = (abort_nxt && double_tap_abort) ? TPEF_IDLE : TPEF_WAIT2;
						cnt_nxt = `TPEF_CNT0;
					end else begin
						cnt_nxt = cnt_inc;
					end
				end
				TPEF_WAIT2: begin
					if (above) begin
						st_nxt = TPEF_HIT2;
						cnt_nxt = `TPEF_CNT0;
						sign_nxt = acc_neg;
					end else if (cnt_r == win) begin
						st_nxt = TPEF_IDLE;
					end else begin
						cnt_nxt = cnt_inc;
					end
				end
				TPEF_HIT2: begin
					if (!above) begin
						double_nxt = 1'b1;
						neg_nxt = sign_r;
						st_nxt = TPEF_IDLE;
					end else if (cnt_r == tmlt) begin
						st_nxt = TPEF_STUCK;
					end else begin
						cnt_nxt = cnt_inc;
					end
				end
				TPEF_STUCK: begin
					// too long above threshold: not a pulse, wait for release
					if (!above)
						st_nxt = TPEF_IDLE;
				end
				default: st_nxt = TPEF_IDLE;
			endcase
		end
	end

	// state registers, frozen while ce is low
	always_ff @(posedge clock) begin
		if (reset) begin
			st_r <= TPEF_IDLE;
			cnt_r <= `TPEF_CNT0;
			sign_r <= 1'b0;
			lat_hit_r <= 1'b0;
			abort_r <= 1'b0;
			single_evt <= 1'b0;
			double_evt <= 1'b0;
			evt_neg <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sign_r <= sign_nxt;
			lat_hit_r <= lat_hit_nxt;
			abort_r <= abort_nxt;
			single_evt <= single_nxt;
			double_evt <= double_nxt;
			evt_neg <= neg_nxt;
		end
	end
endmodule // tpef_axis_det

// ==== rtl/tpef_top.sv ====
// Operation
// - with abort bit clear, double detection continues despite pulses in latency
// - with abort bit set, a pulse inside latency cancels double detection
// - latch enable bit 6 freezes flags in status; clear means no latching
// - six single/double enables per Z, Y, X at config bits 5..0
// - an event reports only if its axis and type are enabled
// - status bit 7 sets when any enabled pulse event occurs
// - status bits 6, 5, 4 flag events on Z, Y, X
// - status bit 3 is one for double, zero for single event
// - status bits 2, 1, 0 give Z, Y, X polarity, one negative
// - with latch enabled, status bits freeze once set until read
// - reading status clears all its bits and the pending interrupt
// - each axis has a 7-bit unsigned threshold starting detection
// - 8-bit time limit bounds how long a valid pulse stays above
// - after the first pulse, further pulses during latency never report
`timescale 1ns/1ps
`include "tpef_map.svh"

module tpef_top #(
	parameter int ACC_W = 8,
	parameter tpef_pkg::tpef_byte_t DBL_WIN_STEPS = `TPEF_DBL_WIN_DEF
) (
	input logic clock,
	input logic reset,
	input logic ce,
	input logic sample_tick,
	input logic signed [ACC_W-1:0] acc_x,
	input logic signed [ACC_W-1:0] acc_y,
	input logic signed [ACC_W-1:0] acc_z,
	input tpef_pkg::tpef_byte_t reg_addr,
	input logic reg_wr,
	input tpef_pkg::tpef_byte_t reg_wdata,
	input logic reg_rd,
	output tpef_pkg::tpef_byte_t reg_rdata,
	output logic pulse_irq
);
	import tpef_pkg::*;

	// the magnitude compare needs room for a sign above the threshold
	generate
		if (ACC_W < `TPEF_THS_W + 1) begin : g_bad_width
			$error("tpef_top: ACC_W must exceed the threshold width");
		end
	endgenerate

	tpef_byte_t cfg_r, cfg_nxt;
	tpef_ths_t thx_r, thx_nxt;
	tpef_ths_t thy_r, thy_nxt;
	tpef_ths_t thz_r, thz_nxt;
	tpef_byte_t tmlt_r, tmlt_nxt;
	tpef_byte_t ltcy_r, ltcy_nxt;
	tpef_byte_t src_r, src_nxt;

	// address decode for the register port
	wire hit_cfg = reg_addr == `TPEF_ADDR_CFG;
	wire hit_src = reg_addr == `TPEF_ADDR_SRC;
	wire hit_thx = reg_addr == `TPEF_ADDR_THX;
	wire hit_thy = reg_addr == `TPEF_ADDR_THY;
	wire hit_thz = reg_addr == `TPEF_ADDR_THZ;
	wire hit_tmlt = reg_addr == `TPEF_ADDR_TMLT;
	wire hit_ltcy = reg_addr == `TPEF_ADDR_LTCY;

	// write strobes; status is read-only so a write there is dropped
	wire wr_cfg = reg_wr & hit_cfg;
	wire wr_thx = reg_wr & hit_thx;
	wire wr_thy = reg_wr & hit_thy;
	wire wr_thz = reg_wr & hit_thz;
	wire wr_tmlt = reg_wr & hit_tmlt;
	wire wr_ltcy = reg_wr & hit_ltcy;
	wire rd_src = reg_rd & hit_src;

	// writable register next values
	assign cfg_nxt = wr_cfg ? reg_wdata : cfg_r;
	assign thx_nxt = wr_thx ? reg_wdata[`TPEF_THS_W-1:0] : thx_r;
	assign thy_nxt = wr_thy ? reg_wdata[`TPEF_THS_W-1:0] : thy_r;
	assign thz_nxt = wr_thz ? reg_wdata[`TPEF_THS_W-1:0] : thz_r;
	assign tmlt_nxt = wr_tmlt ? reg_wdata : tmlt_r;
	assign ltcy_nxt = wr_ltcy ? reg_wdata : ltcy_r;

	// configuration fields, axis index 0 is x, 2 is z
	wire double_tap_abort = cfg_r[`TPEF_CFG_ABORT];
	wire latch_en = cfg_r[`TPEF_CFG_LATCH];
	wire [2:0] single_en = {cfg_r[`TPEF_CFG_ZS], cfg_r[`TPEF_CFG_YS],
		cfg_r[`TPEF_CFG_XS]};
	wire [2:0] double_en = {cfg_r[`TPEF_CFG_ZD], cfg_r[`TPEF_CFG_YD],
		cfg_r[`TPEF_CFG_XD]};

	// per-axis detector inputs gathered for the generate loop
	logic signed [ACC_W-1:0] acc_arr [3];
	tpef_ths_t thr_arr [3];
	assign acc_arr[0] = acc_x;
	assign acc_arr[1] = acc_y;
	assign acc_arr[2] = acc_z;
	assign thr_arr[0] = thx_r;
	assign thr_arr[1] = thy_r;
	assign thr_arr[2] = thz_r;

	tpef_axes_t det_single, det_double, det_neg;

	// one detector per axis; all share time limit, latency and abort
	genvar ax;
	generate
		for (ax = 0; ax < 3; ax++) begin : g_axis
			tpef_axis_det #(
				.ACC_W(ACC_W)
			) tpef_axis_det_i (
				.clock(clock),
				.reset(reset),
				.ce(ce),
				.tick(sample_tick),
				.acc(acc_arr[ax]),
				.thr(thr_arr[ax]),
				.tmlt(tmlt_r),
				.ltcy(ltcy_r),
				.win(DBL_WIN_STEPS),
				.double_tap_abort(double_tap_abort),
				.single_evt(det_single[ax]),
				.double_evt(det_double[ax]),
				.evt_neg(det_neg[ax])
			);
		end
	endgenerate

	// only enabled axis/type pairs become reportable events
	wire [2:0] ev_single = det_single & single_en;
	wire [2:0] ev_double = det_double & double_en;
	wire [2:0] ev_axis = ev_single | ev_double;
	wire ev_any = |ev_axis;
	wire ev_dbl = |ev_double;

	// a read clears the register, but an event in the same cycle still lands
	wire [7:0] src_base = rd_src ? `TPEF_RST8 : src_r;
	wire event_active = src_r[`TPEF_SRC_ACTIVE];
	wire frozen = latch_en & event_active & ~rd_src;
	wire take = ev_any & ~frozen;

	wire [2:0] base_axis = {src_base[`TPEF_SRC_AZ], src_base[`TPEF_SRC_AY],
		src_base[`TPEF_SRC_AX]};
	wire [2:0] base_pol = {src_base[`TPEF_SRC_PZ], src_base[`TPEF_SRC_PY],
		src_base[`TPEF_SRC_PX]};
	// with latching off, axes accumulate and polarity follows the newest event
	wire [2:0] axis_new = latch_en ? ev_axis : (base_axis | ev_axis);
	wire [2:0] pol_new = (base_pol & ~ev_axis & {3{~latch_en}}) | (det_neg & ev_axis);

	// assemble status next value by field position
	always_comb begin
		src_nxt = src_base;
		if (take) begin
			src_nxt[`TPEF_SRC_ACTIVE] = 1'b1;
			src_nxt[`TPEF_SRC_AZ] = axis_new[2];
			src_nxt[`TPEF_SRC_AY] = axis_new[1];
			src_nxt[`TPEF_SRC_AX] = axis_new[0];
			src_nxt[`TPEF_SRC_DOUBLE] = ev_dbl;
			src_nxt[`TPEF_SRC_PZ] = pol_new[2];
			src_nxt[`TPEF_SRC_PY] = pol_new[1];
			src_nxt[`TPEF_SRC_PX] = pol_new[0];
		end
	end

	// read mux; threshold bit 7 and unmapped addresses read zero
	wire [7:0] rd_mux =
		hit_cfg ? cfg_r :
		hit_src ? src_r :
		hit_thx ? {1'b0, thx_r} :
		hit_thy ? {1'b0, thy_r} :
		hit_thz ? {1'b0, thz_r} :
		hit_tmlt ? tmlt_r :
		hit_ltcy ? ltcy_r :
		`TPEF_RST8;
	wire [7:0] rdata_nxt = reg_rd ? rd_mux : reg_rdata;

	// configuration and timing registers
	always_ff @(posedge clock) begin
		if (reset) begin
			cfg_r <= `TPEF_RST8;
			thx_r <= `TPEF_RST7;
			thy_r <= `TPEF_RST7;
			thz_r <= `TPEF_RST7;
			tmlt_r <= `TPEF_RST8;
			ltcy_r <= `TPEF_RST8;
		end else if (ce) begin
			cfg_r <= cfg_nxt;
			thx_r <= thx_nxt;
			thy_r <= thy_nxt;
			thz_r <= thz_nxt;
			tmlt_r <= tmlt_nxt;
			ltcy_r <= ltcy_nxt;
		end
	end

	// status register and its read-clear
	always_ff @(posedge clock) begin
		if (reset)
			src_r <= `TPEF_RST8;
		else if (ce)
			src_r <= src_nxt;
	end

	// read data holds the pre-clear value until the next read
	always_ff @(posedge clock) begin
		if (reset)
			reg_rdata <= `TPEF_RST8;
		else if (ce)
			reg_rdata <= rdata_nxt;
	end

	// interrupt mirrors next event-active so it rises with the flag
	always_ff @(posedge clock) begin
		if (reset)
			pulse_irq <= 1'b0;
		else if (ce)
			pulse_irq <= src_nxt[`TPEF_SRC_ACTIVE];
	end
endmodule // tpef_top

// ==== verif/tpef_checker.sv ====
`timescale 1ns/1ps
module tpef_checker (
	input logic clock,
	input logic reset,
	input logic ce,
	input logic sample_tick,
	input tpef_pkg::tpef_byte_t reg_addr,
	input logic reg_wr,
	input tpef_pkg::tpef_byte_t reg_wdata,
	input logic reg_rd,
	input tpef_pkg::tpef_byte_t reg_rdata,
	input logic pulse_irq
);
	import tpef_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// status read taken on this edge
	wire rd_src = ce && reg_rd && reg_addr == 8'h22;
	// write then read of config, one idle cycle between
	sequence s_cfg_wr;
		ce && reg_wr && reg_addr == 8'h21;
	endsequence
	sequence s_cfg_rd;
		ce && reg_rd && !reg_wr && reg_addr == 8'h21;
	endsequence
	a_reset_clears_out: assert property (disable iff (1'b0)
		reset |=> !pulse_irq && reg_rdata == 8'h00) else $error("outputs not cleared by reset");
	a_read_active_irq: assert property (rd_src |=> reg_rdata[7] == $past(pulse_irq))
		else $error("event bit disagrees with irq");
	a_read_drops_irq: assert property (
		rd_src && !sample_tick && !$past(sample_tick) && !$past(sample_tick, 2) |=> !pulse_irq)
		else $error("irq kept after status read");
	a_irq_holds: assert property (pulse_irq && !rd_src |=> pulse_irq)
		else $error("irq dropped without read");
	a_irq_needs_tick: assert property (
		$rose(pulse_irq) |-> $past(sample_tick, 2) || $past(sample_tick, 3))
		else $error("irq rose without a sample");
	a_thr_msb_zero: assert property (
		ce && reg_rd && reg_addr inside {[8'h23:8'h25]} |=> !reg_rdata[7])
		else $error("threshold top bit set");
	a_cfg_readback: assert property (
		s_cfg_wr ##1 !reg_wr ##1 s_cfg_rd |=> reg_rdata == $past(reg_wdata, 3))
		else $error("config readback differs");
	a_rdata_holds: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
		else $error("read data moved without read");
endmodule // tpef_checker

bind tpef_top tpef_checker tpef_checker_i (.clock(clock), .reset(reset), .ce(ce),
	.sample_tick(sample_tick), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_irq(pulse_irq));

// ==== verif/tpef_host.sv ====
`timescale 1ns/1ps
module tpef_host (
	input logic clock,
	output tpef_pkg::tpef_byte_t reg_addr,
	output logic reg_wr,
	output tpef_pkg::tpef_byte_t reg_wdata,
	output logic reg_rd,
	input tpef_pkg::tpef_byte_t reg_rdata
);
	import tpef_pkg::*;
	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines show junk so stale values never pass
	task automatic wr(input tpef_byte_t a, input tpef_byte_t d);
		@(posedge clock) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clock) #1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
		reg_addr = ~a;
	endtask
	// data lands on the edge that takes the strobe
	task automatic rd(input tpef_byte_t a, output tpef_byte_t d);
		@(posedge clock) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clock) #1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule // tpef_host

// ==== verif/tb_tpef_top.sv ====
`timescale 1ns/1ps
module tb_tpef_top;
	import tpef_pkg::*;
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("MISMATCH %s exp %h got %h", n, e, g); \
	end \
end
	logic clock, reset, ce, sample_tick, reg_wr, reg_rd, pulse_irq;
	logic signed [7:0] acc_x, acc_y, acc_z;
	tpef_byte_t reg_addr, reg_wdata, reg_rdata, d;
	int fails, comparisons, i;
	tpef_top #(.ACC_W(8), .DBL_WIN_STEPS(8'h04)) tpef_top_i (.clock(clock), .reset(reset),
		.ce(ce), .sample_tick(sample_tick), .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pulse_irq(pulse_irq));
	tpef_host tpef_host_i (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// 25 MHz
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task rr(input tpef_byte_t a, input tpef_byte_t e);
		tpef_host_i.rd(a, d);
		`CHK("reg", e, d)
	endtask
	// one sample on axis a, then two cycles for the status to land
	task step(input int a, input logic signed [7:0] v);
		@(posedge clock) #1;
		acc_x = (a == 0) ? v : 8'sh00;
		acc_y = (a == 1) ? v : 8'sh00;
		acc_z = (a == 2) ? v : 8'sh00;
		sample_tick = 1'b1;
		@(posedge clock) #1;
		sample_tick = 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task pulse(input int a, input logic signed [7:0] v);
		step(a, v);
		step(a, 8'sh00);
	endtask
	// quiet samples let latency and double window run out
	task idle(input int n);
		repeat (n) step(0, 8'sh00);
	endtask
	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		results;
	end
	initial begin
		{reset, ce, sample_tick, acc_x, acc_y, acc_z} = {3'b110, 24'h000000};
		fails = 0;
		comparisons = 0;
		repeat (8) @(posedge clock);
		#1 reset = 1'b0;
		rr(8'h21, 8'h00);
		rr(8'h22, 8'h00);
		tpef_host_i.wr(8'h22, 8'hff);
		rr(8'h22, 8'h00);
		tpef_host_i.wr(8'h23, 8'hff);
		rr(8'h23, 8'h7f);
		tpef_host_i.wr(8'h21, 8'ha5);
		rr(8'h21, 8'ha5);
		for (i = 8'h23; i < 8'h26; i++) tpef_host_i.wr(i[7:0], 8'h0a);
		tpef_host_i.wr(8'h26, 8'h02);
		tpef_host_i.wr(8'h27, 8'h01);
		tpef_host_i.wr(8'h21, 8'h6a);
		pulse(0, -8'sd20);
		idle(12);
		rr(8'h22, 8'h00);
		tpef_host_i.wr(8'h21, 8'h41);
		repeat (4) step(0, 8'sd20);
		idle(12);
		rr(8'h22, 8'h00);
		for (i = 0; i < 6; i++) begin
			tpef_host_i.wr(8'h21, 8'h40 | (8'h01 << (2 * (i % 3))));
			pulse(i % 3, (i < 3) ? -8'sd20 : 8'sd20);
			`CHK("irq", 1'b1, pulse_irq)
			rr(8'h22, 8'h80 | (8'h10 << (i % 3)) | ((i < 3) ? 8'h01 << (i % 3) : 8'h00));
			`CHK("irq", 1'b0, pulse_irq)
			idle(12);
		end
		tpef_host_i.wr(8'h21, 8'h42);
		pulse(0, 8'sd20);
		idle(3);
		pulse(0, -8'sd20);
		rr(8'h22, 8'h99);
		idle(12);
		tpef_host_i.wr(8'h21, 8'h45);
		pulse(0, -8'sd20);
		idle(12);
		pulse(1, 8'sd20);
		rr(8'h22, 8'h91);
		idle(12);
		tpef_host_i.wr(8'h21, 8'h05);
		pulse(0, -8'sd20);
		idle(12);
		pulse(1, 8'sd20);
		tpef_host_i.rd(8'h22, d);
		`CHK("axes", 8'hb0, d & 8'hf0)
		idle(12);
		// a pulse inside latency, then one after it
		tpef_host_i.wr(8'h27, 8'h04);
		for (i = 0; i < 2; i++) begin
			tpef_host_i.wr(8'h21, i ? 8'h42 : 8'hc2);
			pulse(0, 8'sd20);
			pulse(0, 8'sd20);
			idle(3);
			pulse(0, 8'sd20);
			rr(8'h22, i ? 8'h98 : 8'h00);
			idle(14);
		end
		// frozen core must drop a write while clock enable is low
		@(posedge clock) #1 ce = 1'b0;
		tpef_host_i.wr(8'h26, 8'h55);
		ce = 1'b1;
		rr(8'h26, 8'h02);
		results;
	end
endmodule // tb_tpef_top
